// File: src/timer_pkg.sv
package timer_pkg;

  // Word byte offsets on the register bus
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] A_LOW_OFFSET = 8'h04;
  localparam logic [7:0] A_HIGH_OFFSET = 8'h08;
  localparam logic [7:0] B_CMP_OFFSET = 8'h0C;
  localparam logic [7:0] FF_OFFSET = 8'h10;
  localparam logic [7:0] A_COUNT_OFFSET = 8'h14;
  localparam logic [7:0] B_COUNT_OFFSET = 8'h18;
  localparam logic [7:0] IRQ_STATUS_OFFSET = 8'h1C;
  localparam logic [7:0] IRQ_MASK_OFFSET = 8'h20;
  localparam logic [7:0] PRESCALE_OFFSET = 8'h24;

  // Control register fields
  localparam int CTRL_A_MODE_LSB = 0;
  localparam int CTRL_A_EDGE_BIT = 2;
  localparam int CTRL_A_EN_BIT = 3;
  localparam int CTRL_B_MODE_LSB = 4;
  localparam int CTRL_B_START_BIT = 6;

  // Interrupt status and mask bits
  localparam int IRQ_A_BIT = 0;
  localparam int IRQ_B_BIT = 1;

  // Counter limits
  localparam logic [7:0] B_COUNT_MAX = 8'hFF;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [15:0] A_COUNT_ZERO = 16'h0000;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

  typedef enum logic [1:0] {A_TIMER, A_COUNTER, A_WINDOW, A_SPARE} a_mode_t;
  typedef enum logic [1:0] {B_TIMER, B_COUNTER, B_DIVIDER, B_PWM} b_mode_t;

  // Wishbone request as seen by the slave
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [7:0] adr;
    logic [31:0] dat;
  } wb_req_t;

  // Whole state of the timer block
  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    a_mode_t a_mode;
    logic a_edge;
    logic a_en;
    b_mode_t b_mode;
    logic b_start;
    logic [7:0] presc;
    logic [7:0] presc_cnt;
    logic int_clk;
    logic [7:0] a_low;
    logic [7:0] a_high;
    logic a_inhibit;
    logic [15:0] a_cnt;
    logic a_pin_prev;
    logic gate_prev;
    logic [7:0] b_buf;
    logic [7:0] b_act;
    logic [7:0] b_cnt;
    logic b_pin_prev;
    logic ff;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;
  } state_t;

endpackage

// File: src/dual_timer.sv
`timescale 1ns/1ps
module dual_timer (
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [3:0] i_wb_sel,
  input wire logic [7:0] i_wb_adr,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  input wire logic i_unit_a_external_input,
  input wire logic i_unit_b_external_input,
  output logic o_divider_output_pin,
  output logic o_pwm_output_pin,
  output logic o_irq
);
  import timer_pkg::*;

  state_t state_reg;
  state_t state_next;
  wb_req_t req;

  // Rising edge between two samples of a level
  function automatic logic rose(input logic prev, input logic cur);
    rose = cur & ~prev;
  endfunction

  // Byte lane 0 is the only lane that carries writable register data
  function automatic logic lane0(input wb_req_t r);
    lane0 = r.sel[0];
  endfunction

  // Group the bus request so the next-state logic reads one bundle
  assign req = '{cyc: i_wb_cyc, stb: i_wb_stb, we: i_wb_we, sel: i_wb_sel,
                 adr: i_wb_adr, dat: i_wb_dat};

  // Next-state logic for the bus slave and both counting units
  always_comb begin
    logic access;
    logic wr;
    logic int_tick;
    logic int_rise;
    logic gate;
    logic a_event;
    logic a_pin_edge;
    logic a_match;
    logic [15:0] a_cmp;
    logic [15:0] a_inc;
    logic b_event;
    logic [7:0] b_inc;
    logic b_match;
    logic b_over;
    logic [1:0] irq_set;
    logic [1:0] irq_clr;
    access = 1'b0;
    wr = 1'b0;
    int_tick = 1'b0;
    int_rise = 1'b0;
    gate = 1'b0;
    a_event = 1'b0;
    a_pin_edge = 1'b0;
    a_match = 1'b0;
    a_cmp = A_COUNT_ZERO;
    a_inc = A_COUNT_ZERO;
    b_event = 1'b0;
    b_inc = BYTE_ZERO;
    b_match = 1'b0;
    b_over = 1'b0;
    irq_set = 2'h0;
    irq_clr = 2'h0;
    state_next = state_reg;

    // Bus handshake: one wait state, ack dropped the cycle after
    access = req.cyc & req.stb & ~state_reg.ack;
    wr = access & req.we & lane0(req);
    state_next.ack = access;

    // Internal counting clock: a square wave from the prescaler
    int_tick = (state_reg.presc_cnt == state_reg.presc);
    if (int_tick) begin
      state_next.presc_cnt = BYTE_ZERO;
      state_next.int_clk = ~state_reg.int_clk;
    end else begin
      state_next.presc_cnt = state_reg.presc_cnt + 8'h01;
    end
    int_rise = int_tick & ~state_reg.int_clk;

    // Pin history for edge detection, pins are already synchronous
    gate = state_reg.int_clk & i_unit_a_external_input;
    state_next.gate_prev = gate;
    state_next.a_pin_prev = i_unit_a_external_input;
    state_next.b_pin_prev = i_unit_b_external_input;

    // Unit A event source by mode
    if (state_reg.a_edge) begin
      a_pin_edge = rose(i_unit_a_external_input, state_reg.a_pin_prev);
    end else begin
      a_pin_edge = rose(state_reg.a_pin_prev, i_unit_a_external_input);
    end
    case (state_reg.a_mode)
      A_TIMER: a_event = int_rise;
      A_COUNTER: a_event = a_pin_edge;
      A_WINDOW: a_event = rose(state_reg.gate_prev, gate);
      default: a_event = 1'b0;
    endcase

    // Unit A count and compare; a match of count plus one ends the period
    a_cmp = {state_reg.a_high, state_reg.a_low};
    a_inc = state_reg.a_cnt + 16'h0001;
    a_match = (a_inc == a_cmp) & ~state_reg.a_inhibit;
    if (state_reg.a_en && a_event) begin
      if (a_match) begin
        state_next.a_cnt = A_COUNT_ZERO;
        irq_set[IRQ_A_BIT] = 1'b1;
      end else begin
        state_next.a_cnt = a_inc;
      end
    end

    // Unit B event source by mode
    case (state_reg.b_mode)
      B_COUNTER: b_event = rose(state_reg.b_pin_prev, i_unit_b_external_input);
      default: b_event = int_rise;
    endcase

    // Unit B count, compare and output flip-flop
    b_inc = state_reg.b_cnt + 8'h01;
    b_match = (b_inc == state_reg.b_act);
    b_over = (state_reg.b_cnt == B_COUNT_MAX);
    if (state_reg.b_start && b_event) begin
      if (state_reg.b_mode == B_PWM) begin
        // Overflow closes the output cycle; only then does a new duty apply
        if (b_over) begin
          state_next.b_cnt = BYTE_ZERO;
          state_next.b_act = state_reg.b_buf;
          irq_set[IRQ_B_BIT] = 1'b1;
        end else begin
          state_next.b_cnt = b_inc;
        end
        state_next.ff = state_reg.ff ^ b_match ^ b_over;
      end else if (b_match) begin
        state_next.b_cnt = BYTE_ZERO;
        irq_set[IRQ_B_BIT] = 1'b1;
        if (state_reg.b_mode == B_DIVIDER) begin
          state_next.ff = ~state_reg.ff;
        end
      end else begin
        state_next.b_cnt = b_inc;
      end
    end

    // Register writes
    if (wr) begin
      case (req.adr)
        CTRL_OFFSET: begin
          state_next.a_mode = a_mode_t'(req.dat[CTRL_A_MODE_LSB +: 2]);
          state_next.a_edge = req.dat[CTRL_A_EDGE_BIT];
          state_next.a_en = req.dat[CTRL_A_EN_BIT];
          state_next.b_mode = b_mode_t'(req.dat[CTRL_B_MODE_LSB +: 2]);
          state_next.b_start = req.dat[CTRL_B_START_BIT];
          // Starting unit B takes the loaded compare value into use
          if (req.dat[CTRL_B_START_BIT]) begin
            state_next.b_act = state_reg.b_buf;
          end
        end
        A_LOW_OFFSET: begin
          state_next.a_low = req.dat[7:0];
          state_next.a_inhibit = 1'b1;
        end
        A_HIGH_OFFSET: begin
          state_next.a_high = req.dat[7:0];
          state_next.a_inhibit = 1'b0;
        end
        B_CMP_OFFSET: begin
          state_next.b_buf = req.dat[7:0];
          // Outside PWM there is no second stage to wait for
          if (state_reg.b_mode != B_PWM) begin
            state_next.b_act = req.dat[7:0];
          end
        end
        FF_OFFSET: state_next.ff = req.dat[0];
        IRQ_STATUS_OFFSET: irq_clr = req.dat[1:0];
        IRQ_MASK_OFFSET: state_next.irq_mask = req.dat[1:0];
        PRESCALE_OFFSET: begin
          state_next.presc = req.dat[7:0];
          state_next.presc_cnt = BYTE_ZERO;
        end
        default: begin
        end
      endcase
    end

    // Sticky interrupt flags; a new event beats a same-cycle clear
    state_next.irq_status = (state_reg.irq_status & ~irq_clr) | irq_set;

    // Registered read data; unmapped words read as zero
    state_next.rdata = WORD_ZERO;
    if (access && !req.we) begin
      case (req.adr)
        CTRL_OFFSET: begin
          state_next.rdata[CTRL_A_MODE_LSB +: 2] = state_reg.a_mode;
          state_next.rdata[CTRL_A_EDGE_BIT] = state_reg.a_edge;
          state_next.rdata[CTRL_A_EN_BIT] = state_reg.a_en;
          state_next.rdata[CTRL_B_MODE_LSB +: 2] = state_reg.b_mode;
          state_next.rdata[CTRL_B_START_BIT] = state_reg.b_start;
        end
        A_LOW_OFFSET: state_next.rdata[7:0] = state_reg.a_low;
        A_HIGH_OFFSET: state_next.rdata[7:0] = state_reg.a_high;
        B_CMP_OFFSET: state_next.rdata[7:0] = state_reg.b_buf;
        FF_OFFSET: state_next.rdata[0] = state_reg.ff;
        A_COUNT_OFFSET: state_next.rdata[15:0] = state_reg.a_cnt;
        B_COUNT_OFFSET: state_next.rdata[7:0] = state_reg.b_cnt;
        IRQ_STATUS_OFFSET: state_next.rdata[1:0] = state_reg.irq_status;
        IRQ_MASK_OFFSET: state_next.rdata[1:0] = state_reg.irq_mask;
        PRESCALE_OFFSET: state_next.rdata[7:0] = state_reg.presc;
        default: state_next.rdata = WORD_ZERO;
      endcase
    end
  end

  // All state in one register; reset also clears the output flip-flop
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs; pins idle high when their mode is not selected
  assign o_wb_ack = state_reg.ack;
  assign o_wb_dat = state_reg.rdata;
  assign o_divider_output_pin = (state_reg.b_mode == B_DIVIDER) ? ~state_reg.ff : 1'b1;
  assign o_pwm_output_pin = (state_reg.b_mode == B_PWM) ? ~state_reg.ff : 1'b1;
  assign o_irq = |(state_reg.irq_status & state_reg.irq_mask);

endmodule

// File: testbench/dual_timer_properties.sv
`timescale 1ns/1ps
module dual_timer_properties (
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic [31:0] o_wb_dat,
  input wire logic o_wb_ack,
  input wire logic o_divider_output_pin,
  input wire logic o_pwm_output_pin,
  input wire logic o_irq
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_reset_n);
  // Bus answer: exactly one cycle after the taken edge, one cycle long
  AST_ACK_PULSE: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack longer than one cycle");
  AST_ACK_AFTER_REQ: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
    else $error("ack missing after request");
  AST_DAT_IDLE: assert property (!o_wb_ack |-> o_wb_dat == 32'h0000_0000)
    else $error("read data outside ack");
  // Only one output mode owns a pin at a time
  AST_PINS_EXCL: assert property (o_divider_output_pin || o_pwm_output_pin)
    else $error("both output pins low");
  AST_RESET_STATE: assert property ($rose(i_reset_n) |-> o_divider_output_pin && o_pwm_output_pin && !o_irq)
    else $error("outputs not idle after reset");
  // Ticks are at least two clocks apart, so a pin never toggles twice running except on a bus write
  AST_PWM_SPACING: assert property ($changed(o_pwm_output_pin) && !o_wb_ack |=> !$changed(o_pwm_output_pin) || o_wb_ack)
    else $error("pwm pin toggled on adjacent cycles");
  AST_DIV_SPACING: assert property ($changed(o_divider_output_pin) && !o_wb_ack |=> !$changed(o_divider_output_pin) || o_wb_ack)
    else $error("divider pin toggled on adjacent cycles");
  // Sticky status: the line drops only through a register write
  AST_IRQ_CLEAR: assert property ($fell(o_irq) |-> o_wb_ack)
    else $error("irq fell without bus write");
  cover property ($rose(o_irq));
  cover property ($fell(o_divider_output_pin));
  cover property ($fell(o_pwm_output_pin));
endmodule
bind dual_timer dual_timer_properties u_properties (.i_clock(i_clock), .i_reset_n(i_reset_n), .i_wb_cyc(i_wb_cyc),
  .i_wb_stb(i_wb_stb), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .o_divider_output_pin(o_divider_output_pin),
  .o_pwm_output_pin(o_pwm_output_pin), .o_irq(o_irq));

// File: testbench/pin_partner.sv
`timescale 1ns/1ps
module pin_partner (
  input wire logic i_clock,
  input wire logic i_pin_level,
  output logic o_pulse = 1'b0,
  output logic [15:0] o_low_len = 16'h0000,
  output logic [15:0] o_high_len = 16'h0000
);
  logic [15:0] run_len = 16'h0000;
  logic last_level = 1'b1;
  // Slow edges, far below the internal clock, so a gate never aliases
  task automatic pulse(input int count);
    repeat (count) begin
      o_pulse <= 1'b1;
      repeat (4) @(posedge i_clock);
      o_pulse <= 1'b0;
      repeat (4) @(posedge i_clock);
    end
  endtask
  // Pin load: length in clocks of the last whole low and high phase
  always @(posedge i_clock) begin
    run_len <= (i_pin_level != last_level) ? 16'h0001 : run_len + 16'h0001;
    last_level <= i_pin_level;
    if (i_pin_level != last_level && last_level) begin
      o_high_len <= run_len;
    end
    if (i_pin_level != last_level && !last_level) begin
      o_low_len <= run_len;
    end
  end
endmodule

// File: testbench/dual_timer_counter_pdo_pwm_bench.sv
`timescale 1ns/1ps
module dual_timer_counter_pdo_pwm_bench;
  import timer_pkg::*;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  wb_req_t req = '0;
  logic [31:0] rdat;
  logic ack;
  logic div_pin;
  logic pwm_pin;
  logic irq;
  logic pulse;
  logic [15:0] low_len;
  logic [15:0] high_len;
  int err_total = 0;
  int comparisons = 0;
  logic [31:0] base;
  dual_timer u_dut (.i_clock(clock), .i_reset_n(reset_n), .i_wb_cyc(req.cyc), .i_wb_stb(req.stb),
    .i_wb_we(req.we), .i_wb_sel(req.sel), .i_wb_adr(req.adr), .i_wb_dat(req.dat), .o_wb_dat(rdat),
    .o_wb_ack(ack), .i_unit_a_external_input(pulse), .i_unit_b_external_input(pulse),
    .o_divider_output_pin(div_pin), .o_pwm_output_pin(pwm_pin), .o_irq(irq));
  pin_partner u_partner (.i_clock(clock), .i_pin_level(div_pin & pwm_pin), .o_pulse(pulse),
    .o_low_len(low_len), .o_high_len(high_len));
  // 10 MHz system clock
  initial forever #50 clock = ~clock;
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One classic cycle; data is taken at the edge that samples ack high
  task automatic bus(input logic [7:0] adr, input logic w, input logic [31:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    req <= '{1'b1, 1'b1, w, 4'hF, adr, wd};
    do begin
      @(posedge clock);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1) begin
      err_total++;
      end_of_test();
    end
    rd = rdat;
    req <= '0;
    @(posedge clock);
  endtask
  task automatic wr(input logic [7:0] adr, input logic [31:0] wd);
    logic [31:0] junk;
    bus(adr, 1'b1, wd, junk);
  endtask
  task automatic rd(input logic [7:0] adr, input logic [31:0] exp);
    logic [31:0] got;
    bus(adr, 1'b0, 32'h0000_0000, got);
    check(got, exp);
  endtask
  // Bounded wait for the interrupt line
  task automatic wait_irq();
    for (int n = 0; n < 400 && irq !== 1'b1; n++) @(posedge clock);
    // A missing interrupt ends the run as a mismatch
    if (irq !== 1'b1) begin
      err_total++;
      $display("mismatch at %0t got %h expected %h", $time, irq, 1'b1);
      end_of_test();
    end
  endtask
  // Main sequence; counter modes run first while both counts are still zero
  initial begin
    repeat (2) @(posedge clock);
    reset_n <= 1'b1;
    check(32'({div_pin, pwm_pin, irq}), 32'h6);
    rd(FF_OFFSET, 32'h0);
    wr(FF_OFFSET, 32'h1);
    rd(FF_OFFSET, 32'h1);
    wr(FF_OFFSET, 32'h0);
    rd(8'h30, 32'h0);
    wr(IRQ_MASK_OFFSET, 32'h3);
    $display("test registers done");
    wr(A_LOW_OFFSET, 32'h2);
    wr(A_HIGH_OFFSET, 32'h0);
    wr(B_CMP_OFFSET, 32'h3);
    wr(CTRL_OFFSET, 32'h5D);
    u_partner.pulse(2);
    rd(IRQ_STATUS_OFFSET, 32'h1);
    u_partner.pulse(1);
    rd(IRQ_STATUS_OFFSET, 32'h3);
    wr(CTRL_OFFSET, 32'h0);
    wr(IRQ_STATUS_OFFSET, 32'h3);
    $display("test counters done");
    wr(B_CMP_OFFSET, 32'h5);
    wr(CTRL_OFFSET, 32'h40);
    wait_irq();
    check(32'(irq), 32'h1);
    wr(CTRL_OFFSET, 32'h0);
    rd(IRQ_STATUS_OFFSET, 32'h2);
    wr(IRQ_STATUS_OFFSET, 32'h2);
    check(32'(irq), 32'h0);
    wr(A_LOW_OFFSET, 32'h8);
    wr(A_HIGH_OFFSET, 32'h0);
    wr(CTRL_OFFSET, 32'h8);
    wait_irq();
    rd(IRQ_STATUS_OFFSET, 32'h1);
    wr(IRQ_STATUS_OFFSET, 32'h1);
    wr(A_LOW_OFFSET, 32'hC);
    repeat (30) @(posedge clock);
    rd(IRQ_STATUS_OFFSET, 32'h0);
    wr(CTRL_OFFSET, 32'h0);
    // Window mode: one slow pulse spans two rising edges of the gate
    wr(A_LOW_OFFSET, 32'hFF);
    wr(A_HIGH_OFFSET, 32'hFF);
    wr(CTRL_OFFSET, 32'hA);
    bus(A_COUNT_OFFSET, 1'b0, 32'h0, base);
    u_partner.pulse(1);
    rd(A_COUNT_OFFSET, base + 32'h2);
    wr(CTRL_OFFSET, 32'h0);
    $display("test timers done");
    wr(B_CMP_OFFSET, 32'h4);
    wr(CTRL_OFFSET, 32'h60);
    repeat (60) @(posedge clock);
    check(32'(low_len), 32'h8);
    check(32'(high_len), 32'h8);
    rd(IRQ_STATUS_OFFSET, 32'h2);
    wr(CTRL_OFFSET, 32'h0);
    wr(IRQ_STATUS_OFFSET, 32'h2);
    wr(FF_OFFSET, 32'h0);
    wr(B_CMP_OFFSET, 32'h40);
    wr(CTRL_OFFSET, 32'h70);
    repeat (1200) @(posedge clock);
    check(32'(low_len), 32'h180);
    check(32'(high_len), 32'h80);
    wr(B_CMP_OFFSET, 32'h80);
    repeat (1200) @(posedge clock);
    check(32'(low_len), 32'h100);
    check(32'(high_len), 32'h100);
    rd(IRQ_STATUS_OFFSET, 32'h2);
    $display("test outputs done");
    end_of_test();
  end
endmodule
